// [rtl/stp_checker.sv]
// Functional notes
// R1 - short pulse above minimum threshold flags underlength fault
// R2 - pulse above maximum threshold too long flags overtension fault
// R3 - duration limits are milliseconds in manual mode, percent in auto mode (code uses ms in auto mode until a sync interval is known)
// R4 - point never reaching or holding minimum is not counted, flags underlength
// R5 - maximum threshold off value disables overtension check
// R6 - any fault asserts stop and error outputs until cleared
// R7 - manual clearing holds fault until button or touch reset (code also clears on a CTRL write with CTRL_OPRST_BIT set)
// R8 - automatic clearing drops fault on next tension pulse
// R9 - stop output polarity selects normally open or normally closed rest
// R10 - sync polarity selects active sense; machine drives line accordingly
// R11 - sync timeout closes run and clears point counter
// R12 - at timeout, counted points compared with programmed total, mismatch faults
// R13 - count check setting enables the end of run comparison
// R14 - run split into sections, each with own count, thresholds, durations
// R15 - section advances after its programmed count of accepted points
// R16 - sync active edge opens point window; durations in millisecond ticks
// R17 - auto percent limit is percentage of last sync interval
//
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
module stp_checker #(
  parameter int MS_CYCLES = stp_pkg::MS_CYCLES
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [stp_pkg::DATA_W-1:0] hwdata,
  input  wire logic                       hready,
  output logic      [stp_pkg::DATA_W-1:0] hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  input  wire logic [stp_pkg::TENS_W-1:0] tension_sample,
  input  wire logic                       sync_in,
  input  wire logic                       button_reset,
  input  wire logic                       touch_reset,
  output logic                            stop_out,
  output logic                            error_out
);
  import stp_pkg::*;

  stp_ctrl_t             ctrl_reg, ctrl_next;
  logic [15:0]           timeout_reg, timeout_next;
  stp_section_t          sec_reg [SEC_MAX];
  stp_section_t          sec_next [SEC_MAX];
  logic                  op_reset;
  logic                  dp_write_reg, dp_write_next;
  logic [11:0]           dp_addr_reg, dp_addr_next;
  logic [DATA_W-1:0]     hrdata_reg, hrdata_next;
  logic                  ap_valid;
  logic [11:0]           sec_off;

  logic [31:0]           div_reg, div_next;
  logic                  tick_reg, tick_next;
  stp_run_state_t        state_reg, state_next;
  logic                  sync_prev_reg;
  logic                  win_open_reg, win_open_next;
  logic [15:0]           since_reg, since_next;
  logic [15:0]           period_reg, period_next;
  logic                  period_ok_reg, period_ok_next;
  logic [TOT_W-1:0]      run_total_reg, run_total_next;
  logic [CNT_W-1:0]      sec_pts_reg, sec_pts_next;
  logic [SEC_IDX_W-1:0]  sec_idx_reg, sec_idx_next;
  stp_faults_t           fault_reg, fault_next;
  logic                  stop_reg, stop_next;
  logic                  error_reg, error_next;

  stp_section_t          cur;
  logic                  sync_act, sync_edge, timeout_hit, close;
  logic                  above_min, above_max, use_pct, accept, over_now, manual_clr;
  logic [15:0]           min_ms, max_ms;
  logic                  pulse_start;
  logic [31:0]           min_lhs, min_rhs, max_lhs, max_rhs;
  logic [TOT_W-1:0]      prog_sum, total_final;

  // ---------------- AHB-Lite slave: zero wait, reads sampled in address phase
  assign ap_valid = hsel & htrans[1] & hready & (hsize == HSIZE_WORD);
  assign op_reset = dp_write_reg && dp_addr_reg == ADDR_CTRL && hwdata[CTRL_OPRST_BIT];

  always_comb begin
    dp_write_next = ap_valid & hwrite;
    dp_addr_next  = ap_valid ? {haddr[11:2], 2'b00} : dp_addr_reg;
    sec_off       = {haddr[11:2], 2'b00} - ADDR_SEC_BASE;
    hrdata_next   = '0;
    if (ap_valid && !hwrite) begin
      if ({haddr[11:2], 2'b00} == ADDR_CTRL) begin
        hrdata_next[CTRL_UNIT_BIT]   = ctrl_reg.unit_auto;
        hrdata_next[CTRL_AUTO_BIT]   = ctrl_reg.auto_clear;
        hrdata_next[CTRL_STOPNC_BIT] = ctrl_reg.stop_nc;
        hrdata_next[CTRL_SYNCNC_BIT] = ctrl_reg.sync_nc;
        hrdata_next[CTRL_CCHK_BIT]   = ctrl_reg.count_check;
        hrdata_next[CTRL_SECS_LSB +: SEC_IDX_W] = ctrl_reg.sections_m1;
      end else if ({haddr[11:2], 2'b00} == ADDR_TIMEOUT) begin
        hrdata_next[15:0] = timeout_reg;
      end else if ({haddr[11:2], 2'b00} == ADDR_STATUS) begin
        hrdata_next[2:0]  = fault_reg;
        hrdata_next[3]    = error_reg;
        hrdata_next[4]    = (state_reg == STP_RUN_ACTIVE);
        hrdata_next[8 +: SEC_IDX_W] = sec_idx_reg;
        hrdata_next[31:16] = run_total_reg[15:0];
      end else if ({haddr[11:2], 2'b00} == ADDR_RUN) begin
        hrdata_next[15:0]  = sec_pts_reg;
        hrdata_next[31:16] = period_reg;
      end else if ({haddr[11:2], 2'b00} >= ADDR_SEC_BASE && {haddr[11:2], 2'b00} < ADDR_SEC_END) begin
        if (sec_off[3:0] == SEC_OFS_COUNT) begin
          hrdata_next[15:0] = sec_reg[sec_off[SEC_IDX_W+3:4]].point_count;
        end else if (sec_off[3:0] == SEC_OFS_THR) begin
          hrdata_next = {sec_reg[sec_off[SEC_IDX_W+3:4]].max_thr, sec_reg[sec_off[SEC_IDX_W+3:4]].min_thr};
        end else if (sec_off[3:0] == SEC_OFS_DUR) begin
          hrdata_next = {sec_reg[sec_off[SEC_IDX_W+3:4]].max_dur, sec_reg[sec_off[SEC_IDX_W+3:4]].min_dur};
        end
      end
    end
  end

  // config writes land in the data phase
  always_comb begin
    ctrl_next    = ctrl_reg;
    timeout_next = timeout_reg;
    for (int s = 0; s < SEC_MAX; s++) begin
      sec_next[s] = sec_reg[s];
      if (dp_write_reg && dp_addr_reg == ADDR_SEC_BASE + 12'(s * 16) + 12'(SEC_OFS_COUNT)) begin // R14
        sec_next[s].point_count = hwdata[15:0];
      end
      if (dp_write_reg && dp_addr_reg == ADDR_SEC_BASE + 12'(s * 16) + 12'(SEC_OFS_THR)) begin
        sec_next[s].min_thr = hwdata[15:0];
        sec_next[s].max_thr = hwdata[31:16];
      end
      if (dp_write_reg && dp_addr_reg == ADDR_SEC_BASE + 12'(s * 16) + 12'(SEC_OFS_DUR)) begin
        sec_next[s].min_dur = hwdata[15:0];
        sec_next[s].max_dur = hwdata[31:16];
      end
    end
    if (dp_write_reg && dp_addr_reg == ADDR_CTRL) begin
      ctrl_next.unit_auto   = hwdata[CTRL_UNIT_BIT];
      ctrl_next.auto_clear  = hwdata[CTRL_AUTO_BIT];
      ctrl_next.stop_nc     = hwdata[CTRL_STOPNC_BIT];
      ctrl_next.sync_nc     = hwdata[CTRL_SYNCNC_BIT];
      ctrl_next.count_check = hwdata[CTRL_CCHK_BIT];
      ctrl_next.sections_m1 = hwdata[CTRL_SECS_LSB +: SEC_IDX_W];
    end else if (dp_write_reg && dp_addr_reg == ADDR_TIMEOUT) begin
      timeout_next = hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg     <= CTRL_RESET;
      timeout_reg  <= TIMEOUT_RESET;
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= '0;
      hrdata_reg   <= '0;
      for (int s = 0; s < SEC_MAX; s++) begin
        sec_reg[s] <= '0;
      end
    end else begin
      ctrl_reg     <= ctrl_next;
      timeout_reg  <= timeout_next;
      dp_write_reg <= dp_write_next;
      dp_addr_reg  <= dp_addr_next;
      hrdata_reg   <= hrdata_next;
      for (int s = 0; s < SEC_MAX; s++) begin
        sec_reg[s] <= sec_next[s];
      end
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ---------------- point checking
  assign cur       = sec_reg[sec_idx_reg];
  assign sync_act  = sync_in ^ ctrl_reg.sync_nc; // R10
  assign sync_edge = sync_act & ~sync_prev_reg; // R16
  assign above_min = tension_sample >= cur.min_thr;
  assign above_max = (cur.max_thr != MAX_THR_OFF) && (tension_sample > cur.max_thr); // R5
  assign timeout_hit = (state_reg == STP_RUN_ACTIVE) && (since_reg >= timeout_reg) && !sync_edge;
  assign close       = (state_reg == STP_RUN_ACTIVE) && (sync_edge || timeout_hit);
  // until one interval is known the limits fall back to milliseconds
  assign use_pct     = ctrl_reg.unit_auto & period_ok_reg; // R3

  stp_pulse_meter u_meter (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .ms_tick      (tick_reg),
    .window_start (sync_edge),
    .above_min    (above_min),
    .above_max    (above_max),
    .min_ms       (min_ms),
    .max_ms       (max_ms),
    .pulse_start  (pulse_start)
  );

  // cross-multiplied so no divider is needed in the percent case
  always_comb begin
    min_lhs = {16'h0000, min_ms};
    min_rhs = {16'h0000, cur.min_dur};
    max_lhs = {16'h0000, max_ms};
    max_rhs = {16'h0000, cur.max_dur};
    if (use_pct) begin // R17
      min_lhs = {16'h0000, min_ms} * PCT_FULL;
      min_rhs = {16'h0000, cur.min_dur} * {16'h0000, period_reg};
      max_lhs = {16'h0000, max_ms} * PCT_FULL;
      max_rhs = {16'h0000, cur.max_dur} * {16'h0000, period_reg};
    end
    accept   = (min_lhs >= min_rhs) && (min_ms != 16'h0000); // R4
    over_now = win_open_reg && (cur.max_thr != MAX_THR_OFF) && (max_lhs > max_rhs); // R2
    prog_sum = '0;
    for (int s = 0; s < SEC_MAX; s++) begin
      if (s <= int'(ctrl_reg.sections_m1)) begin
        prog_sum = prog_sum + TOT_W'(sec_reg[s].point_count);
      end
    end
    total_final = run_total_reg + TOT_W'(accept);
  end

  assign manual_clr = button_reset | touch_reset | op_reset;

  always_comb begin
    div_next       = (div_reg >= 32'(MS_CYCLES - 1)) ? '0 : div_reg + 32'h1;
    tick_next      = (div_reg >= 32'(MS_CYCLES - 1));
    state_next     = state_reg;
    win_open_next  = win_open_reg;
    since_next     = since_reg;
    period_next    = period_reg;
    period_ok_next = period_ok_reg;
    run_total_next = run_total_reg;
    sec_pts_next   = sec_pts_reg;
    sec_idx_next   = sec_idx_reg;
    fault_next     = fault_reg;
    if (!ctrl_reg.auto_clear && manual_clr) begin // R7
      fault_next = '0;
    end else if (ctrl_reg.auto_clear && pulse_start) begin // R8
      fault_next = '0;
    end
    if (tick_reg && state_reg == STP_RUN_ACTIVE && since_reg != 16'hffff) begin
      since_next = since_reg + 16'h0001;
    end
    if (close) begin
      if (accept) begin
        run_total_next = run_total_reg + TOT_W'(1);
        if (sec_pts_reg + 16'h0001 >= cur.point_count && sec_idx_reg < ctrl_reg.sections_m1) begin // R15
          sec_idx_next = sec_idx_reg + SEC_IDX_W'(1);
          sec_pts_next = '0;
        end else begin
          sec_pts_next = sec_pts_reg + 16'h0001;
        end
      end else begin
        fault_next.underlength = 1'b1; // R1
      end
    end
    if (over_now) begin
      fault_next.overtension = 1'b1; // R2
    end
    if (timeout_hit) begin
      if (ctrl_reg.count_check && total_final != prog_sum) begin // R13
        fault_next.count = 1'b1; // R12
      end
      state_next     = STP_RUN_IDLE; // R11
      win_open_next  = 1'b0;
      run_total_next = '0;
      sec_pts_next   = '0;
      sec_idx_next   = '0;
      period_ok_next = 1'b0;
    end else if (sync_edge) begin
      if (state_reg == STP_RUN_ACTIVE) begin
        period_next    = since_reg;
        period_ok_next = (since_reg != 16'h0000);
      end
      state_next    = STP_RUN_ACTIVE;
      win_open_next = 1'b1;
      since_next    = '0;
    end
    error_next = |fault_next; // R6
    stop_next  = (|fault_next) ^ ctrl_reg.stop_nc; // R9
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg       <= '0;
      tick_reg      <= 1'b0;
      state_reg     <= STP_RUN_IDLE;
      sync_prev_reg <= 1'b0;
      win_open_reg  <= 1'b0;
      since_reg     <= '0;
      period_reg    <= '0;
      period_ok_reg <= 1'b0;
      run_total_reg <= '0;
      sec_pts_reg   <= '0;
      sec_idx_reg   <= '0;
      fault_reg     <= '0;
      stop_reg      <= 1'b0;
      error_reg     <= 1'b0;
    end else begin
      div_reg       <= div_next;
      tick_reg      <= tick_next;
      state_reg     <= state_next;
      sync_prev_reg <= sync_act;
      win_open_reg  <= win_open_next;
      since_reg     <= since_next;
      period_reg    <= period_next;
      period_ok_reg <= period_ok_next;
      run_total_reg <= run_total_next;
      sec_pts_reg   <= sec_pts_next;
      sec_idx_reg   <= sec_idx_next;
      fault_reg     <= fault_next;
      stop_reg      <= stop_next;
      error_reg     <= error_next;
    end
  end

  assign stop_out  = stop_reg;
  assign error_out = error_reg;

  // ---------------- assertions
  property p_underlength; // R1
    @(posedge hclk) disable iff (!hresetn) (close && !accept) |=> fault_reg.underlength;
  endproperty
  a_underlength: assert property (p_underlength) else $error("rejected point did not flag underlength"); // R1

  property p_no_count; // R4
    @(posedge hclk) disable iff (!hresetn) (close && !accept && !timeout_hit) |=> $stable(run_total_reg);
  endproperty
  a_no_count: assert property (p_no_count) else $error("rejected point was counted"); // R4

  property p_overtension; // R2
    @(posedge hclk) disable iff (!hresetn) over_now |=> fault_reg.overtension;
  endproperty
  a_overtension: assert property (p_overtension) else $error("overtension not flagged"); // R2

  property p_max_off; // R5
    @(posedge hclk) disable iff (!hresetn) $rose(fault_reg.overtension) |-> $past(cur.max_thr) != MAX_THR_OFF;
  endproperty
  a_max_off: assert property (p_max_off) else $error("overtension with check disabled"); // R5

  property p_outputs; // R6
    @(posedge hclk) disable iff (!hresetn) ##1 (error_out == |fault_reg) && (stop_out == ((|fault_reg) ^ $past(ctrl_reg.stop_nc))); // R9
  endproperty
  a_outputs: assert property (p_outputs) else $error("stop or error output wrong"); // R6

  property p_manual_hold; // R7
    @(posedge hclk) disable iff (!hresetn) (fault_reg.count && !ctrl_reg.auto_clear && !manual_clr) |=> fault_reg.count;
  endproperty
  a_manual_hold: assert property (p_manual_hold) else $error("fault dropped without operator reset"); // R7

  property p_auto_clear; // R8
    @(posedge hclk) disable iff (!hresetn) (ctrl_reg.auto_clear && pulse_start && !close && !over_now && !timeout_hit) |=> fault_reg == '0;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("auto clear did not drop fault"); // R8

  property p_timeout; // R11
    @(posedge hclk) disable iff (!hresetn) timeout_hit |=> (run_total_reg == '0) && (sec_idx_reg == '0) && (state_reg == STP_RUN_IDLE);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not close the run"); // R11

  property p_count; // R12
    @(posedge hclk) disable iff (!hresetn) (timeout_hit && ctrl_reg.count_check && total_final != prog_sum) |=> fault_reg.count; // R13
  endproperty
  a_count: assert property (p_count) else $error("count mismatch not flagged"); // R12

  property p_sync_open; // R16
    @(posedge hclk) disable iff (!hresetn) (sync_edge && state_reg == STP_RUN_IDLE) |=> (state_reg == STP_RUN_ACTIVE) && win_open_reg;
  endproperty
  a_sync_open: assert property (p_sync_open) else $error("sync edge did not open a window"); // R16

endmodule : stp_checker

// [common/stp_pkg.sv]
package stp_pkg;

  localparam int          DATA_W         = 32;
  localparam int          TENS_W         = 16;
  localparam int          CNT_W          = 16;
  localparam int          SEC_MAX        = 4;
  localparam int          SEC_IDX_W      = 2;
  localparam int          TOT_W          = CNT_W + SEC_IDX_W;

  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_TIMEOUT   = 12'h004;
  localparam logic [11:0] ADDR_STATUS    = 12'h008;
  localparam logic [11:0] ADDR_RUN       = 12'h00c;
  localparam logic [11:0] ADDR_SEC_BASE  = 12'h040;
  localparam logic [11:0] ADDR_SEC_END   = 12'h080;
  localparam logic [3:0]  SEC_OFS_COUNT  = 4'h0;
  localparam logic [3:0]  SEC_OFS_THR    = 4'h4;
  localparam logic [3:0]  SEC_OFS_DUR    = 4'h8;

  localparam int          CTRL_UNIT_BIT  = 0;
  localparam int          CTRL_AUTO_BIT  = 1;
  localparam int          CTRL_STOPNC_BIT = 2;
  localparam int          CTRL_SYNCNC_BIT = 3;
  localparam int          CTRL_CCHK_BIT  = 4;
  localparam int          CTRL_OPRST_BIT = 5;
  localparam int          CTRL_SECS_LSB  = 8;

  localparam logic [15:0] TIMEOUT_RESET  = 16'h0064;
  localparam logic [15:0] MAX_THR_OFF    = 16'h0000;
  localparam logic [31:0] PCT_FULL       = 32'h0000_0064;
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;

  localparam int          CLK_PERIOD_NS  = 5;
  localparam int          MS_NS          = 1000000;
  localparam int          MS_CYCLES      = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic {
    STP_RUN_IDLE,
    STP_RUN_ACTIVE
  } stp_run_state_t;

  typedef struct packed {
    logic [SEC_IDX_W-1:0] sections_m1;
    logic                 count_check;
    logic                 sync_nc;
    logic                 stop_nc;
    logic                 auto_clear;
    logic                 unit_auto;
  } stp_ctrl_t;

  localparam stp_ctrl_t   CTRL_RESET     = '{sections_m1: '0, count_check: 1'b1, sync_nc: 1'b0,
                                             stop_nc: 1'b0, auto_clear: 1'b0, unit_auto: 1'b0};

  typedef struct packed {
    logic [CNT_W-1:0]  point_count;
    logic [TENS_W-1:0] max_thr;
    logic [TENS_W-1:0] min_thr;
    logic [15:0]       max_dur;
    logic [15:0]       min_dur;
  } stp_section_t;

  typedef struct packed {
    logic count;
    logic overtension;
    logic underlength;
  } stp_faults_t;

endpackage : stp_pkg

// [rtl/stp_pulse_meter.sv]
module stp_pulse_meter (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ms_tick,
  input  wire logic        window_start,
  input  wire logic        above_min,
  input  wire logic        above_max,
  output logic      [15:0] min_ms,
  output logic      [15:0] max_ms,
  output logic             pulse_start
);
  import stp_pkg::*;

  logic [15:0] min_ms_reg;
  logic [15:0] min_ms_next;
  logic [15:0] max_ms_reg;
  logic [15:0] max_ms_next;
  logic        above_prev_reg;
  logic        pulse_start_reg;
  logic        pulse_start_next;

  // millisecond ticks above each threshold in the open window, saturating
  always_comb begin
    min_ms_next      = min_ms_reg;
    max_ms_next      = max_ms_reg;
    pulse_start_next = above_min & ~above_prev_reg;
    if (window_start) begin
      min_ms_next = '0;
      max_ms_next = '0;
    end else if (ms_tick) begin
      if (above_min && min_ms_reg != 16'hffff) begin // R16
        min_ms_next = min_ms_reg + 16'h0001;
      end
      if (above_max && max_ms_reg != 16'hffff) begin
        max_ms_next = max_ms_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      min_ms_reg      <= '0;
      max_ms_reg      <= '0;
      above_prev_reg  <= 1'b0;
      pulse_start_reg <= 1'b0;
    end else begin
      min_ms_reg      <= min_ms_next;
      max_ms_reg      <= max_ms_next;
      above_prev_reg  <= above_min;
      pulse_start_reg <= pulse_start_next;
    end
  end

  assign min_ms      = min_ms_reg;
  assign max_ms      = max_ms_reg;
  assign pulse_start = pulse_start_reg;

endmodule : stp_pulse_meter

// [bench/stp_machine_model.sv]
module stp_machine_model (
  input  wire logic                  hclk,
  input  wire logic                  pol_nc,
  output logic                       sync_in,
  output logic [stp_pkg::TENS_W-1:0] tension_sample
);
  timeunit 1ns;
  timeprecision 1ps;
  import stp_pkg::*;
  logic act;
  initial begin
    act = 1'b0;
    tension_sample = '0;
  end
  // idles at the inactive level of the chosen sense
  assign sync_in = act ^ pol_nc;
  // one stitch: short sync pulse, tension for hi cycles, then slack
  task automatic point(input logic [TENS_W-1:0] lvl, input int hi, input int gap);
    act <= 1'b1;
    tension_sample <= lvl;
    repeat (2) @(posedge hclk);
    act <= 1'b0;
    repeat (hi - 2) @(posedge hclk);
    tension_sample <= '0;
    repeat (gap) @(posedge hclk);
  endtask : point
endmodule : stp_machine_model

// [bench/test_stitch_tension_pulse_checker.sv]
module test_stitch_tension_pulse_checker;
  timeunit 1ns;
  timeprecision 1ps;
  import stp_pkg::*;
  `define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
  // short ms tick keeps runs brief; all durations scale with it
  localparam int MS = 10;
  logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]       haddr, hwdata, hrdata, rd;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic              button_reset, touch_reset, pol_nc, stop_out, error_out, sync_in;
  logic [TENS_W-1:0] tension_sample;
  int                err_total, checks_done, cyc;

  initial hclk = 1'b0;
  always #2.5 hclk = ~hclk;

  stp_checker #(.MS_CYCLES(MS)) i_stp_checker (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .tension_sample(tension_sample), .sync_in(sync_in), .button_reset(button_reset),
    .touch_reset(touch_reset), .stop_out(stop_out), .error_out(error_out));
  stp_machine_model i_stp_machine_model (
    .hclk(hclk), .pol_nc(pol_nc), .sync_in(sync_in), .tension_sample(tension_sample));

  task automatic report_and_stop();
    $display("mismatches %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // hang guard, far above the roughly 1250 cycles the tests need
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wr ? d : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd & m, e)
  endtask : rd_chk

  task automatic set_sec(input int s, input logic [15:0] cnt, mn, mx, mnd, mxd);
    bus(1'b1, ADDR_SEC_BASE + 12'(s * 16) + {8'h0, SEC_OFS_COUNT}, {16'h0, cnt});
    bus(1'b1, ADDR_SEC_BASE + 12'(s * 16) + {8'h0, SEC_OFS_THR}, {mx, mn});
    bus(1'b1, ADDR_SEC_BASE + 12'(s * 16) + {8'h0, SEC_OFS_DUR}, {mxd, mnd});
  endtask : set_sec

  // 3 ms above minimum in a 4 ms stitch; short one stays under one tick
  task automatic good(input int n);
    repeat (n) i_stp_machine_model.point(16'h00c8, 30, 10);
  endtask : good

  task automatic short_pt();
    i_stp_machine_model.point(16'h00c8, 4, 36);
  endtask : short_pt

  task automatic wait_idle();
    for (int i = 0; i < 60; i++) begin
      bus(1'b0, ADDR_STATUS, 32'h0);
      if (rd[4] === 1'b0) break;
    end
    repeat (2) @(posedge hclk);
  endtask : wait_idle

  task automatic clr(input logic touch);
    if (touch) begin
      touch_reset <= 1'b1;
    end else begin
      button_reset <= 1'b1;
    end
    @(posedge hclk);
    touch_reset <= 1'b0;
    button_reset <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask : clr

  initial begin
    {hresetn, hsel, hwrite, button_reset, touch_reset, pol_nc} = '0;
    {haddr, hwdata, htrans, hsize} = '0;
    {err_total, checks_done, cyc} = '0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK(stop_out, 1'b0)
    rd_chk(ADDR_CTRL, 32'hffff_ffff, 32'h0000_0010);
    rd_chk(ADDR_TIMEOUT, 32'hffff_ffff, 32'h0000_0064);
    bus(1'b1, 12'h100, 32'hffff_ffff);
    rd_chk(12'h100, 32'hffff_ffff, 32'h0);
    bus(1'b1, ADDR_STATUS, 32'hffff_ffff);
    rd_chk(ADDR_STATUS, 32'hffff_ffff, 32'h0);
    bus(1'b1, ADDR_TIMEOUT, 32'h0000_0006);
    set_sec(0, 16'h0003, 16'h0064, 16'h0000, 16'h0002, 16'h0000);
    good(3);
    rd_chk(ADDR_STATUS, 32'hffff_001f, 32'h0002_0010);
    wait_idle();
    rd_chk(ADDR_STATUS, 32'hffff_ffff, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h0);
    good(2);
    wait_idle();
    rd_chk(ADDR_STATUS, 32'hf, 32'h0);
    set_sec(0, 16'h0001, 16'h0064, 16'h0000, 16'h0002, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, ADDR_CTRL, 32'h10 | (32'(k) << 2));
      // stop register follows the control write one cycle late
      repeat (2) @(posedge hclk);
      `CHK(stop_out, 1'(k))
      short_pt();
      wait_idle();
      rd_chk(ADDR_STATUS, 32'hf, 32'hd);
      `CHK(error_out, 1'b1)
      `CHK(stop_out, ~1'(k))
      good(1);
      `CHK(error_out, 1'b1)
      wait_idle();
      clr(1'(k));
      rd_chk(ADDR_STATUS, 32'hf, 32'h0);
      `CHK(stop_out, 1'(k))
    end
    bus(1'b1, ADDR_CTRL, 32'h02);
    short_pt();
    wait_idle();
    `CHK(error_out, 1'b1)
    good(1);
    `CHK(error_out, 1'b0)
    wait_idle();
    rd_chk(ADDR_STATUS, 32'hf, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h110);
    set_sec(0, 16'h0002, 16'h0064, 16'h0000, 16'h0002, 16'h0000);
    set_sec(1, 16'h0001, 16'h0064, 16'h0000, 16'h0004, 16'h0000);
    good(3);
    rd_chk(ADDR_STATUS, 32'hffff_0300, 32'h0002_0100);
    wait_idle();
    rd_chk(ADDR_STATUS, 32'hf, 32'hd);
    clr(1'b0);
    // percent mode: first point has no interval yet, so 40 is taken as ms there
    bus(1'b1, ADDR_CTRL, 32'h11);
    set_sec(0, 16'h0002, 16'h0064, 16'h0000, 16'h0028, 16'h0000);
    good(3);
    rd_chk(ADDR_STATUS, 32'hffff_0001, 32'h0001_0001);
    wait_idle();
    rd_chk(ADDR_STATUS, 32'hf, 32'h9);
    clr(1'b0);
    // polarity swap may fake one edge: let that run close and clear it
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, ADDR_CTRL, 32'h10 | (32'(m) << 3));
      pol_nc <= 1'(m);
      set_sec(0, 16'h0001, 16'h0064, m ? 16'h0000 : 16'h0096, 16'h0002, 16'h0001);
      wait_idle();
      clr(1'b0);
      good(1);
      wait_idle();
      rd_chk(ADDR_STATUS, 32'hf, m ? 32'h0 : 32'ha);
      clr(1'b0);
    end
    report_and_stop();
  end
endmodule : test_stitch_tension_pulse_checker
